// File: rtl/psmc_pkg.sv
// Package of constants and types for the pin state mode controller
// ********************************************************************
// ********************************************************************
package psmc_pkg;

  // ******************************************************************
  // Widths, reset values and the BOOT_SINGLE boot mode value
  // ******************************************************************
  localparam int ADDR_W      = 22;
  localparam int ADDR_LO_W   = 18;
  localparam int DATA_W      = 32;
  localparam int STROBE_W    = 3;
  localparam int PORT_W      = 16;
  localparam int BOOT_W      = 2;
  localparam logic [BOOT_W-1:0] BOOT_RESET  = 2'h0;
  localparam logic [BOOT_W-1:0] BOOT_SINGLE = 2'h3;
  localparam logic              HI_PORT_RESET = 1'h1;

  // ******************************************************************
  // Chip modes, Gray coded in the order listed
  // ******************************************************************
  typedef enum logic [2:0] {
    MS_POR       = 3'h0,
    MS_NORMAL    = 3'h1,
    MS_BUS_REL   = 3'h3,
    MS_STBY_BREL = 3'h2,
    MS_STANDBY   = 3'h6,
    MS_SLEEP     = 3'h7,
    MS_MANUAL    = 3'h5
  } psmc_mode_e;

  // Per-group pad action
  typedef enum logic [2:0] {
    ACT_FOLLOW = 3'h0,
    ACT_HIZ    = 3'h1,
    ACT_HIGH   = 3'h2,
    ACT_LOW    = 3'h3,
    ACT_KEEP   = 3'h4
  } psmc_act_e;

  // Core side bus values
  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                data_oe;
    logic [STROBE_W-1:0] strobe_n;
  } psmc_bus_s;

endpackage

// File: rtl/psmc_pin_cell.sv
// Registered pad driver for one pin group
`timescale 1ns/1ps
module psmc_pin_cell #(
  parameter int W = 1
) (
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  input  wire psmc_pkg::psmc_act_e act_in,
  input  wire logic                keep_float_in,
  input  wire logic [W-1:0]        core_out_in,
  input  wire logic [W-1:0]        core_oe_in,
  output logic      [W-1:0]        pad_out,
  output logic      [W-1:0]        pad_oe_n_out
);
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;
  logic [W-1:0] oe_n_reg;
  logic [W-1:0] oe_n_next;

  // ******************************************************************
  // Next pad state
  // ******************************************************************
  always_comb begin
    out_next  = out_reg;
    oe_n_next = oe_n_reg;
    case (act_in)
      psmc_pkg::ACT_FOLLOW: begin
        out_next  = core_out_in;
        oe_n_next = ~core_oe_in;
      end
      psmc_pkg::ACT_HIZ: begin
        oe_n_next = {W{1'b1}};
      end
      psmc_pkg::ACT_HIGH: begin
        out_next  = {W{1'b1}};
        oe_n_next = {W{1'b0}};
      end
      psmc_pkg::ACT_LOW: begin
        out_next  = {W{1'b0}};
        oe_n_next = {W{1'b0}};
      end
      psmc_pkg::ACT_KEEP: begin
        out_next  = out_reg;
        oe_n_next = oe_n_reg | {W{keep_float_in}};
      end
      default: begin
        oe_n_next = {W{1'b1}};
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_reg  <= {W{1'b0}};
      oe_n_reg <= {W{1'b1}};
    end else begin
      out_reg  <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign pad_out      = out_reg;
  assign pad_oe_n_out = oe_n_reg;
endmodule

// File: rtl/psmc_top.sv
// Pin state mode controller: chip mode tracking and pad state selection
`timescale 1ns/1ps
module psmc_top #(
  parameter int PORT_W = psmc_pkg::PORT_W
) (
  input  wire logic                              clk_in,
  input  wire logic                              reset_n_in,
  input  wire logic                              system_init_pin_n_in,
  input  wire logic                              manual_reset_n_in,
  input  wire logic                              standby_req_in,
  input  wire logic                              sleep_req_in,
  input  wire logic                              wake_in,
  input  wire logic                              bus_request_in,
  input  wire logic                              standby_hiz_in,
  input  wire logic [psmc_pkg::BOOT_W-1:0]       boot_mode_in,
  input  wire logic                              addr_hi_sel_in,
  input  wire psmc_pkg::psmc_bus_s               core_bus_in,
  input  wire logic [PORT_W-1:0]                 port_out_in,
  input  wire logic [PORT_W-1:0]                 port_oe_in,
  output psmc_pkg::psmc_mode_e                   mode_out,
  output logic                                   addr_hi_port_out,
  output logic [psmc_pkg::ADDR_W-1:0]            addr_out,
  output logic [psmc_pkg::ADDR_W-1:0]            addr_oe_n_out,
  output logic [psmc_pkg::DATA_W-1:0]            data_out,
  output logic [psmc_pkg::DATA_W-1:0]            data_oe_n_out,
  output logic [psmc_pkg::STROBE_W-1:0]          strobe_n_out,
  output logic [psmc_pkg::STROBE_W-1:0]          strobe_oe_n_out,
  output logic                                   bus_ack_n_out,
  output logic                                   bus_ack_oe_n_out,
  output logic [PORT_W-1:0]                      port_out,
  output logic [PORT_W-1:0]                      port_oe_n_out
);
  localparam int HI_W = psmc_pkg::ADDR_W - psmc_pkg::ADDR_LO_W;

  psmc_pkg::psmc_mode_e          mode_reg;
  psmc_pkg::psmc_mode_e          mode_next;
  logic [psmc_pkg::BOOT_W-1:0]   boot_reg;
  logic [psmc_pkg::BOOT_W-1:0]   boot_next;
  logic                          hi_port_reg;
  logic                          hi_port_next;
  logic                          ext_bus;
  psmc_pkg::psmc_act_e           act_addr_lo;
  psmc_pkg::psmc_act_e           act_addr_hi;
  psmc_pkg::psmc_act_e           act_data;
  psmc_pkg::psmc_act_e           act_strobe;
  psmc_pkg::psmc_act_e           act_ack;
  psmc_pkg::psmc_act_e           act_port;
  logic                          keep_float;

  // ******************************************************************
  // Mode tracking
  // ******************************************************************
  always_comb begin
    mode_next    = mode_reg;
    boot_next    = boot_reg;
    hi_port_next = hi_port_reg;
    if (!system_init_pin_n_in) begin
      mode_next    = psmc_pkg::MS_POR;
      boot_next    = boot_mode_in;
      hi_port_next = psmc_pkg::HI_PORT_RESET;
    end else if (!manual_reset_n_in) begin
      mode_next = psmc_pkg::MS_MANUAL;
    end else begin
      if (addr_hi_sel_in) begin
        hi_port_next = 1'b0;
      end
      case (mode_reg)
        psmc_pkg::MS_POR, psmc_pkg::MS_MANUAL: begin
          mode_next = psmc_pkg::MS_NORMAL;
        end
        psmc_pkg::MS_NORMAL: begin
          if (standby_req_in) begin
            mode_next = psmc_pkg::MS_STANDBY;
          end else if (bus_request_in) begin
            mode_next = psmc_pkg::MS_BUS_REL;
          end else if (sleep_req_in) begin
            mode_next = psmc_pkg::MS_SLEEP;
          end
        end
        psmc_pkg::MS_SLEEP: begin
          if (bus_request_in) begin
            mode_next = psmc_pkg::MS_BUS_REL;
          end else if (!sleep_req_in || wake_in) begin
            mode_next = psmc_pkg::MS_NORMAL;
          end
        end
        psmc_pkg::MS_BUS_REL: begin
          if (standby_req_in) begin
            mode_next = psmc_pkg::MS_STBY_BREL;
          end else if (!bus_request_in) begin
            mode_next = psmc_pkg::MS_NORMAL;
          end
        end
        psmc_pkg::MS_STANDBY: begin
          if (wake_in) begin
            mode_next = psmc_pkg::MS_NORMAL;
          end
        end
        psmc_pkg::MS_STBY_BREL: begin
          if (wake_in) begin
            mode_next = bus_request_in ? psmc_pkg::MS_BUS_REL : psmc_pkg::MS_NORMAL;
          end
        end
        default: begin
          mode_next = psmc_pkg::MS_POR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_reg    <= psmc_pkg::MS_POR;
      boot_reg    <= psmc_pkg::BOOT_RESET;
      hi_port_reg <= psmc_pkg::HI_PORT_RESET;
    end else begin
      mode_reg    <= mode_next;
      boot_reg    <= boot_next;
      hi_port_reg <= hi_port_next;
    end
  end

  // ******************************************************************
  // Pad action per group
  // ******************************************************************
  always_comb begin
    ext_bus     = (boot_reg != psmc_pkg::BOOT_SINGLE);
    keep_float  = standby_hiz_in;
    act_addr_lo = psmc_pkg::ACT_HIZ;
    act_addr_hi = psmc_pkg::ACT_HIZ;
    act_data    = psmc_pkg::ACT_HIZ;
    act_strobe  = psmc_pkg::ACT_HIZ;
    act_ack     = psmc_pkg::ACT_HIZ;
    act_port    = psmc_pkg::ACT_HIZ;
    case (mode_reg)
      psmc_pkg::MS_POR: begin
        act_addr_lo = ext_bus ? psmc_pkg::ACT_FOLLOW : psmc_pkg::ACT_HIZ;
        act_strobe  = ext_bus ? psmc_pkg::ACT_HIGH : psmc_pkg::ACT_HIZ;
        act_addr_hi = psmc_pkg::ACT_HIZ;
        act_port    = psmc_pkg::ACT_HIZ;
      end
      psmc_pkg::MS_NORMAL, psmc_pkg::MS_MANUAL, psmc_pkg::MS_SLEEP: begin
        act_addr_lo = psmc_pkg::ACT_FOLLOW;
        act_addr_hi = hi_port_reg ? psmc_pkg::ACT_HIZ : psmc_pkg::ACT_FOLLOW;
        act_data    = psmc_pkg::ACT_FOLLOW;
        act_strobe  = psmc_pkg::ACT_FOLLOW;
        act_ack     = psmc_pkg::ACT_HIGH;
        act_port    = (mode_reg == psmc_pkg::MS_SLEEP) ? psmc_pkg::ACT_KEEP
                                                       : psmc_pkg::ACT_FOLLOW;
        keep_float  = 1'b0;
      end
      psmc_pkg::MS_BUS_REL: begin
        act_ack  = psmc_pkg::ACT_LOW;
        act_port = psmc_pkg::ACT_FOLLOW;
      end
      psmc_pkg::MS_STANDBY: begin
        act_port = psmc_pkg::ACT_KEEP;
      end
      psmc_pkg::MS_STBY_BREL: begin
        act_ack  = psmc_pkg::ACT_LOW;
        act_port = psmc_pkg::ACT_KEEP;
      end
      default: begin
        act_port = psmc_pkg::ACT_HIZ;
      end
    endcase
  end

  // ******************************************************************
  // Pad groups
  // ******************************************************************
  psmc_pin_cell #(.W(psmc_pkg::ADDR_LO_W)) u_addr_lo (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .act_in        (act_addr_lo),
    .keep_float_in (1'b0),
    .core_out_in   (core_bus_in.addr[psmc_pkg::ADDR_LO_W-1:0]),
    .core_oe_in    ({psmc_pkg::ADDR_LO_W{1'b1}}),
    .pad_out       (addr_out[psmc_pkg::ADDR_LO_W-1:0]),
    .pad_oe_n_out  (addr_oe_n_out[psmc_pkg::ADDR_LO_W-1:0])
  );

  psmc_pin_cell #(.W(HI_W)) u_addr_hi (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .act_in        (act_addr_hi),
    .keep_float_in (1'b0),
    .core_out_in   (core_bus_in.addr[psmc_pkg::ADDR_W-1:psmc_pkg::ADDR_LO_W]),
    .core_oe_in    ({HI_W{1'b1}}),
    .pad_out       (addr_out[psmc_pkg::ADDR_W-1:psmc_pkg::ADDR_LO_W]),
    .pad_oe_n_out  (addr_oe_n_out[psmc_pkg::ADDR_W-1:psmc_pkg::ADDR_LO_W])
  );

  psmc_pin_cell #(.W(psmc_pkg::DATA_W)) u_data (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .act_in        (act_data),
    .keep_float_in (1'b0),
    .core_out_in   (core_bus_in.data),
    .core_oe_in    ({psmc_pkg::DATA_W{core_bus_in.data_oe}}),
    .pad_out       (data_out),
    .pad_oe_n_out  (data_oe_n_out)
  );

  psmc_pin_cell #(.W(psmc_pkg::STROBE_W)) u_strobe (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .act_in        (act_strobe),
    .keep_float_in (1'b0),
    .core_out_in   (core_bus_in.strobe_n),
    .core_oe_in    ({psmc_pkg::STROBE_W{1'b1}}),
    .pad_out       (strobe_n_out),
    .pad_oe_n_out  (strobe_oe_n_out)
  );

  psmc_pin_cell #(.W(1)) u_ack (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .act_in        (act_ack),
    .keep_float_in (1'b0),
    .core_out_in   (1'b1),
    .core_oe_in    (1'b1),
    .pad_out       (bus_ack_n_out),
    .pad_oe_n_out  (bus_ack_oe_n_out)
  );

  psmc_pin_cell #(.W(PORT_W)) u_port (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .act_in        (act_port),
    .keep_float_in (keep_float),
    .core_out_in   (port_out_in),
    .core_oe_in    (port_oe_in),
    .pad_out       (port_out),
    .pad_oe_n_out  (port_oe_n_out)
  );

  assign mode_out         = mode_reg;
  assign addr_hi_port_out = hi_port_reg;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_standby_keep_hold: assert property (
    (mode_reg == psmc_pkg::MS_STANDBY && $past(mode_reg) == psmc_pkg::MS_STANDBY
     && !standby_hiz_in) |=> ($stable(port_out) && $stable(port_oe_n_out)))
    else $error("kept port pins changed in standby");

  a_standby_hiz_float: assert property (
    (mode_reg == psmc_pkg::MS_STANDBY && standby_hiz_in) |=> (&port_oe_n_out))
    else $error("port pins driven with standby high impedance set");

  a_por_addr_hi: assert property (
    (mode_reg == psmc_pkg::MS_POR) ##1 (mode_reg == psmc_pkg::MS_NORMAL && hi_port_reg)
    |=> (&addr_oe_n_out[psmc_pkg::ADDR_W-1:psmc_pkg::ADDR_LO_W]))
    else $error("upper address lines driven after power-on reset");

  a_standby_wins: assert property (
    (system_init_pin_n_in && manual_reset_n_in && mode_reg == psmc_pkg::MS_NORMAL
     && standby_req_in && bus_request_in) |=> (mode_reg == psmc_pkg::MS_STANDBY))
    else $error("bus release won over standby entry");

  a_boot_strobes: assert property (
    (mode_reg == psmc_pkg::MS_POR) |=>
      ($past(ext_bus) ? (strobe_oe_n_out == '0 && &strobe_n_out) : (&strobe_oe_n_out)))
    else $error("reset strobe state does not follow boot mode");

  a_bus_release_pins: assert property (
    (mode_reg == psmc_pkg::MS_BUS_REL) |=>
      (!bus_ack_n_out && !bus_ack_oe_n_out && (&data_oe_n_out) && (&addr_oe_n_out)
       && (&strobe_oe_n_out)))
    else $error("bus not released with acknowledge low");

  c_standby: cover property (mode_reg == psmc_pkg::MS_STANDBY ##1 wake_in);
  c_bus_rel: cover property (mode_reg == psmc_pkg::MS_BUS_REL ##1
                             mode_reg == psmc_pkg::MS_STBY_BREL);
  c_sleep:   cover property (mode_reg == psmc_pkg::MS_SLEEP ##1
                             mode_reg == psmc_pkg::MS_NORMAL);
endmodule

// File: test/psmc_board_model.sv
// Board model that drives the init pin and the bus release request
`timescale 1ns/1ps
module psmc_board_model (
  input  wire logic clk_in,
  output logic      system_init_pin_n_out,
  output logic      bus_request_out
);
  // ******************************************************************
  // Board actions, changed just after a falling edge
  // ******************************************************************
  initial begin
    system_init_pin_n_out = 1'h0;
    bus_request_out       = 1'h0;
  end

  // Port levels are not looked at while the init pin is low
  task automatic drive_init(input logic level, input int delay);
    repeat (delay) @(negedge clk_in);
    system_init_pin_n_out = level;
  endtask

  // Prompt with delay 0, slow otherwise
  task automatic drive_request(input logic level, input int delay);
    repeat (delay) @(negedge clk_in);
    bus_request_out = level;
  endtask
endmodule

// File: test/testbench.sv
// Self-checking testbench for the pin state mode controller
`timescale 1ns/1ps
module testbench;
  logic                 clk, rst_n, init_n, man_rst_n, stby, slp, wake, bus_req, hiz, sel;
  logic                 a_port, ack_n, ack_oe_n;
  logic [1:0]           boot;
  logic [15:0]          p_out, p_oe, port_pad, port_oe_n;
  logic [21:0]          addr, addr_oe_n;
  logic [31:0]          data, data_oe_n;
  logic [2:0]           strb, strb_oe_n;
  psmc_pkg::psmc_bus_s  core;
  psmc_pkg::psmc_mode_e mode;
  int                   num_errors, compares;

  psmc_board_model board (.clk_in(clk), .system_init_pin_n_out(init_n),
                          .bus_request_out(bus_req));

  psmc_top dut (
    .clk_in(clk), .reset_n_in(rst_n), .system_init_pin_n_in(init_n),
    .manual_reset_n_in(man_rst_n), .standby_req_in(stby), .sleep_req_in(slp),
    .wake_in(wake), .bus_request_in(bus_req), .standby_hiz_in(hiz), .boot_mode_in(boot),
    .addr_hi_sel_in(sel), .core_bus_in(core), .port_out_in(p_out), .port_oe_in(p_oe),
    .mode_out(mode), .addr_hi_port_out(a_port), .addr_out(addr), .addr_oe_n_out(addr_oe_n),
    .data_out(data), .data_oe_n_out(data_oe_n), .strobe_n_out(strb),
    .strobe_oe_n_out(strb_oe_n), .bus_ack_n_out(ack_n), .bus_ack_oe_n_out(ack_oe_n),
    .port_out(port_pad), .port_oe_n_out(port_oe_n)
  );

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_mode(input psmc_pkg::psmc_mode_e exp);
    compares++;
    if (mode !== exp) begin
      num_errors++;
      $display("[ERR] %0t mode %0h exp %0h", $time, mode, exp);
    end
  endtask

  task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t pins %0h exp %0h", $time, got, exp);
    end
  endtask

  // Bounded wait for a mode, then one edge for the pads
  task automatic wait_mode(input psmc_pkg::psmc_mode_e exp);
    int n;
    n = 0;
    while (mode !== exp && n < 4) begin
      cyc(1);
      n++;
    end
    chk_mode(exp);
    if (mode !== exp) final_report();
    cyc(1);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_power_on(input logic [1:0] b);
    boot = b;
    board.drive_init(1'h0, 0);
    wait_mode(psmc_pkg::MS_POR);
    chk_bits(port_oe_n, 32'hffff);
    chk_bits(data_oe_n, 32'hffffffff);
    chk_bits(ack_oe_n, 32'h1);
    chk_bits(a_port, 32'h1);
    chk_bits(addr_oe_n, (b == psmc_pkg::BOOT_SINGLE) ? 32'h3fffff : 32'h3c0000);
    chk_bits(strb_oe_n, (b == psmc_pkg::BOOT_SINGLE) ? 32'h7 : 32'h0);
    chk_bits(strb | strb_oe_n, 32'h7);
    board.drive_init(1'h1, 2);
    wait_mode(psmc_pkg::MS_NORMAL);
    chk_bits(addr_oe_n[21:18], 32'hf);
  endtask

  task automatic t_normal;
    p_oe = 16'h00ff;
    p_out = 16'h0f0f;
    hiz = 1'h1;
    cyc(3);
    chk_bits(port_oe_n, 32'hff00);
    chk_bits(port_pad[7:0], 32'h0f);
    chk_bits(data_oe_n, 32'h0);
    chk_bits(data, 32'hc33c5aa5);
    chk_bits(strb, 32'h5);
    chk_bits({ack_oe_n, ack_n}, 32'h1);
    sel = 1'h1;
    cyc(1);
    sel = 1'h0;
    cyc(3);
    chk_bits({a_port, addr_oe_n}, 32'h0);
    chk_bits(addr, 32'h15a5a5);
    hiz = 1'h0;
  endtask

  task automatic t_standby(input logic h);
    hiz = h;
    stby = 1'h1;
    wait_mode(psmc_pkg::MS_STANDBY);
    stby = 1'h0;
    p_out = 16'hf0f0;
    p_oe = 16'hffff;
    cyc(2);
    chk_bits(port_oe_n, h ? 32'hffff : 32'hff00);
    chk_bits(port_pad[7:0], 32'h0f);
    chk_bits({ack_oe_n, data_oe_n[0], strb_oe_n}, 32'h1f);
    wake = 1'h1;
    wait_mode(psmc_pkg::MS_NORMAL);
    wake = 1'h0;
    hiz = 1'h0;
    chk_bits(port_oe_n, 32'h0);
    p_oe = 16'h00ff;
    p_out = 16'h0f0f;
    cyc(2);
  endtask

  task automatic t_bus_release;
    board.drive_request(1'h1, 3);
    wait_mode(psmc_pkg::MS_BUS_REL);
    chk_bits(addr_oe_n, 32'h3fffff);
    chk_bits(data_oe_n & {29'h0, strb_oe_n}, 32'h7);
    chk_bits({ack_oe_n, ack_n, port_oe_n}, 32'hff00);
    stby = 1'h1;
    wait_mode(psmc_pkg::MS_STBY_BREL);
    stby = 1'h0;
    p_out = 16'hf0f0;
    cyc(2);
    chk_bits({ack_oe_n, ack_n, port_pad[7:0]}, 32'h0f);
    wake = 1'h1;
    wait_mode(psmc_pkg::MS_BUS_REL);
    wake = 1'h0;
    board.drive_request(1'h0, 0);
    wait_mode(psmc_pkg::MS_NORMAL);
    p_out = 16'h0f0f;
  endtask

  task automatic t_collide;
    stby = 1'h1;
    board.drive_request(1'h1, 0);
    cyc(1);
    chk_mode(psmc_pkg::MS_STANDBY);
    stby = 1'h0;
    wake = 1'h1;
    board.drive_request(1'h0, 0);
    wait_mode(psmc_pkg::MS_NORMAL);
    wake = 1'h0;
  endtask

  task automatic t_sleep_manual;
    slp = 1'h1;
    hiz = 1'h1;
    wait_mode(psmc_pkg::MS_SLEEP);
    p_out = 16'hf0f0;
    cyc(2);
    chk_bits({port_oe_n, port_pad[7:0]}, 32'hff000f);
    slp = 1'h0;
    hiz = 1'h0;
    wait_mode(psmc_pkg::MS_NORMAL);
    man_rst_n = 1'h0;
    wait_mode(psmc_pkg::MS_MANUAL);
    chk_bits({ack_oe_n, ack_n}, 32'h1);
    man_rst_n = 1'h1;
    wait_mode(psmc_pkg::MS_NORMAL);
    slp = 1'h1;
    wait_mode(psmc_pkg::MS_SLEEP);
    board.drive_request(1'h1, 0);
    wait_mode(psmc_pkg::MS_BUS_REL);
    chk_bits({ack_oe_n, ack_n}, 32'h0);
    slp = 1'h0;
    board.drive_request(1'h0, 0);
    wait_mode(psmc_pkg::MS_NORMAL);
  endtask

  // ******************************************************************
  // Clock, reset and main sequence
  // ******************************************************************
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    num_errors = 0;
    compares = 0;
    {rst_n, stby, slp, wake, hiz, sel} = 6'h0;
    man_rst_n = 1'h1;
    boot = psmc_pkg::BOOT_RESET;
    core = '0;
    core.data = 32'hc33c5aa5;
    core.addr = 22'h15a5a5;
    core.data_oe = 1'h1;
    core.strobe_n = 3'h5;
    p_out = 16'h0;
    p_oe = 16'h0;
    cyc(8);
    chk_bits({a_port, ack_oe_n, port_oe_n}, 32'h3ffff);
    rst_n = 1'h1;
    t_power_on(psmc_pkg::BOOT_RESET);
    t_normal();
    t_standby(1'h0);
    t_standby(1'h1);
    t_bus_release();
    t_collide();
    t_sleep_manual();
    t_power_on(psmc_pkg::BOOT_SINGLE);
    final_report();
  end
endmodule
